// ===== include/flash_defs.svh
// constants for the flash write/erase lock-and-key block
`ifndef FLASH_DEFS_SVH
`define FLASH_DEFS_SVH

// ==========================================================
// special function register addresses
`define PSC_ADDR            8'h8F
`define KEY_ADDR            8'hB7

// ==========================================================
// program_store_control fields and reset
`define PSC_WE_BIT          0
`define PSC_EE_BIT          1
`define PSC_RESET           8'h00

// ==========================================================
// flash_lock_key codes and reset
`define KEY_FIRST           8'hA5
`define KEY_SECOND          8'hF1
`define KEY_RESET           8'h00

// ==========================================================
// flash geometry: low address bits that select a byte in a page
`define PAGE_BITS           9
`define ERASED_BYTE         8'hFF

`endif

// ===== include/flash_pkg.sv
// types and shared helpers of the flash lock-and-key block
`default_nettype none
`include "flash_defs.svh"

package flash_pkg;

  // ==========================================================
  // lock state, binary codes as seen in the key register
  typedef enum logic [1:0] {
    LOCK_LOCKED   = 2'b00,  // writes and erases refused
    LOCK_KEY_ONE  = 2'b01,  // first key code seen
    LOCK_OPEN     = 2'b10,  // one operation allowed
    LOCK_DISABLED = 2'b11   // refused until reset
  } lock_state_t;

  typedef logic [15:0] xaddr_t;

  // ==========================================================
  // base address of the page holding an address
  function automatic xaddr_t pageBase(input xaddr_t addr);
    pageBase = {addr[15:`PAGE_BITS], {`PAGE_BITS{1'b0}}};
  endfunction

endpackage

`default_nettype wire

// ===== src/external_move_instruction_router.sv
// steers external-move writes to flash program, page erase or data memory
`default_nettype none
`include "flash_defs.svh"

module external_move_instruction_router (
  // control bits
  input  wire logic                 writeEnable,
  input  wire logic                 eraseEnable,
  // external-move write
  input  wire logic                 movxWrite,
  input  wire flash_pkg::xaddr_t    movxAddr,
  input  wire logic [7:0]           movxData,
  // routed results
  output logic                      toFlash,
  output logic                      toErase,
  output logic                      toData,
  output flash_pkg::xaddr_t         flashAddr,
  output logic [7:0]                flashData
);

  // ==========================================================
  // routing decode
  assign toFlash   = movxWrite && writeEnable;
  assign toData    = movxWrite && !writeEnable;
  assign toErase   = toFlash && eraseEnable;
  // an erase works on the whole page and drops the data byte
  assign flashAddr = eraseEnable ? flash_pkg::pageBase(movxAddr) : movxAddr;
  assign flashData = eraseEnable ? `ERASED_BYTE : movxData;

endmodule // external_move_instruction_router

`default_nettype wire

// ===== src/flash_write_erase_lock_key.sv
// top of the flash write/erase lock-and-key control block
// external_move_instruction_router steers each external-move write,
// key_lock_fsm judges each flash write made with a good supply against the key codes,
// and this level registers every strobe.
// a supply fault raises the error reset and
// leaves the lock as it was.
`default_nettype none
`include "flash_defs.svh"

module flash_write_erase_lock_key (
  // clock and reset
  input  wire logic                 mclk,
  input  wire logic                 resetn,

  // special function register port of the cpu core
  // one-cycle strobes, no wait states
  input  wire logic [7:0]           sfrAddr,
  input  wire logic                 sfrWrite,
  input  wire logic                 sfrRead,
  input  wire logic [7:0]           sfrWdata,
  output logic [7:0]                sfrRdata,

  // external-move write from the cpu core
  // one-cycle strobe with its operands
  input  wire logic                 movxWrite,
  input  wire flash_pkg::xaddr_t    movxAddr,
  input  wire logic [7:0]           movxData,

  // supply monitor status
  // both high for any flash operation
  input  wire logic                 supplyMonEnabled,
  input  wire logic                 supplyMonIsResetSource,

  // flash array
  // strobes out, done pulse back
  input  wire logic                 flashDone,
  output logic                      flashProgram,
  output logic                      flashErase,
  output flash_pkg::xaddr_t         flashAddr,
  output logic [7:0]                flashData,

  // external data memory
  // used while flash writes are off
  output logic                      xramWrite,
  output flash_pkg::xaddr_t         xramAddr,
  output logic [7:0]                xramData,

  // reset request and status
  // status is for polling only
  output logic                      flashErrorReset,
  output logic [1:0]                lockState,
  output logic                      flashBusy
);

  // ==========================================================
  // declarations

  // reset image, named so its bits can be picked
  localparam logic [7:0] pscReset = `PSC_RESET;

  // program_store_control storage, only the two live bits
  // reserved bits have no storage
  logic                   writeEnable_q;     // store_write_enable
  logic                   writeEnable_d;
  logic                   eraseEnable_q;     // page_erase_enable
  logic                   eraseEnable_d;

  // register port decode
  logic                   selPsc;            // address hits program_store_control
  logic                   selKey;            // address hits flash_lock_key
  logic                   pscWrite;          // write strobe for control register
  logic                   keyWrite;          // write strobe for key register
  logic [7:0]             pscReadValue;      // control register as read
  logic [7:0]             keyReadValue;      // key register as read
  logic [7:0]             readMux;           // selected read data
  logic [7:0]             sfrRdata_q;        // registered read data
  logic [7:0]             sfrRdata_d;

  // routing results
  // meaningful in a write cycle only
  logic                   routeFlash;        // write aims at flash
  logic                   routeErase;        // write aims at a page erase
  logic                   routeData;         // write aims at data memory
  flash_pkg::xaddr_t      routeAddr;         // flash address or page base
  logic [7:0]             routeData8;        // byte to program

  // lock machine interface
  // single-cycle events but the state and supplyOk
  flash_pkg::lock_state_t state;             // current lock state
  logic                   supplyOk;          // monitor on and used as reset source
  logic                   attempt;           // attempt that the lock machine judges
  logic                   grant;             // operation may start
  logic                   opDone;            // running operation finished

  // operation tracking
  logic                   opBusy_q;          // flash operation in flight
  logic                   opBusy_d;

  // registered outputs
  // one flop per pin, next value beside the address, data and error reset flops
  logic                   flashProgram_q;
  logic                   flashErase_q;
  flash_pkg::xaddr_t      flashAddr_q;
  flash_pkg::xaddr_t      flashAddr_d;
  logic [7:0]             flashData_q;
  logic [7:0]             flashData_d;
  logic                   xramWrite_q;
  flash_pkg::xaddr_t      xramAddr_q;
  flash_pkg::xaddr_t      xramAddr_d;
  logic [7:0]             xramData_q;
  logic [7:0]             xramData_d;
  logic                   errReset_q;
  logic                   errReset_d;
  logic [1:0]             lockState_q;

  // ==========================================================
  // register port decode
  assign selPsc   = (sfrAddr == `PSC_ADDR);
  assign selKey   = (sfrAddr == `KEY_ADDR);
  assign pscWrite = sfrWrite && selPsc;
  assign keyWrite = sfrWrite && selKey;
  // other addresses fall through unseen

  // reserved bits of the control register are not stored
  // and read back as zero
  assign pscReadValue = {6'h00, eraseEnable_q, writeEnable_q};
  // the key register shows the lock state, not the last code written
  assign keyReadValue = {6'h00, state};

  // unmapped addresses read as zero
  // rather than stale bus data
  assign readMux = selPsc ? pscReadValue :
                   selKey ? keyReadValue : 8'h00;

  // a key read shows the state before a same-cycle key write
  // read data is held until the next read, so a slow core may sample late
  assign sfrRdata_d = sfrRead ? readMux : sfrRdata_q;

  // ==========================================================
  // control register next value
  // nothing but a register write sets them
  // both bits stay set until firmware clears them; an operation
  // does not clear them, only the lock state closes again
  // bits 7:2 of the written byte are dropped
  assign writeEnable_d = pscWrite ? sfrWdata[`PSC_WE_BIT] : writeEnable_q;
  assign eraseEnable_d = pscWrite ? sfrWdata[`PSC_EE_BIT] : eraseEnable_q;

  // ==========================================================
  // control register storage
  // reset leaves flash writes blocked
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      // both bits start cleared
      writeEnable_q <= pscReset[`PSC_WE_BIT];
      eraseEnable_q <= pscReset[`PSC_EE_BIT];
    end else begin
      // held unless the register is written
      writeEnable_q <= writeEnable_d;
      eraseEnable_q <= eraseEnable_d;
    end
  end

  // ==========================================================
  // external-move routing
  // write enable picks the target
  // combinational; results are registered
  external_move_instruction_router u_router (
    .writeEnable (writeEnable_q),
    .eraseEnable (eraseEnable_q),
    .movxWrite   (movxWrite),
    .movxAddr    (movxAddr),
    .movxData    (movxData),
    .toFlash     (routeFlash),
    .toErase     (routeErase),
    .toData      (routeData),
    .flashAddr   (routeAddr),
    .flashData   (routeData8)
  );

  // ==========================================================
  // lock decisions
  // the lock sees judged attempts only
  // a bad supply monitor set-up resets the device instead of
  // touching the lock, so such an attempt is kept away from it
  assign supplyOk = supplyMonEnabled && supplyMonIsResetSource;
  // a good supply is needed to be judged
  assign attempt  = routeFlash && supplyOk;
  // one operation at a time; the array must report done first
  // and both key codes must have been seen
  assign grant    = attempt && (state == flash_pkg::LOCK_OPEN) && !opBusy_q;
  // a done pulse while idle is ignored
  assign opDone   = flashDone && opBusy_q;
  // raised whatever the lock state is
  assign errReset_d = routeFlash && !supplyOk;

  // key codes, relock and permanent lock
  key_lock_fsm u_lock (
    .mclk     (mclk),
    .resetn   (resetn),
    .keyWrite (keyWrite),
    .keyData  (sfrWdata),
    .attempt  (attempt),
    .busy     (opBusy_q),
    .opDone   (opDone),
    .state    (state)
  );

  // ==========================================================
  // operation tracking: busy from grant until the array reports done
  // grant needs idle, done needs busy
  assign opBusy_d = grant ? 1'b1 : (opDone ? 1'b0 : opBusy_q);

  // ==========================================================
  // next values of the address and data outputs
  // they hold their last value between strobes
  // data memory operands follow each data write
  assign flashAddr_d = grant ? routeAddr : flashAddr_q;
  assign flashData_d = grant ? routeData8 : flashData_q;
  assign xramAddr_d  = routeData ? movxAddr : xramAddr_q;
  assign xramData_d  = routeData ? movxData : xramData_q;

  // ==========================================================
  // operation strobes and tracking registers
  // strobes are one-cycle pulses
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      // nothing runs after reset
      flashProgram_q <= 1'b0;
      flashErase_q   <= 1'b0;
      xramWrite_q    <= 1'b0;
      errReset_q     <= 1'b0;
      opBusy_q       <= 1'b0;
    end else begin
      // a grant programs unless erase is set
      flashProgram_q <= grant && !routeErase;
      flashErase_q   <= grant && routeErase;
      xramWrite_q    <= routeData;
      errReset_q     <= errReset_d;
      opBusy_q       <= opBusy_d;
    end
  end

  // ==========================================================
  // address, data and status registers
  // operands stay put while the array works
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      // operands and read data start at zero
      flashAddr_q <= 16'h0000;
      flashData_q <= 8'h00;
      xramAddr_q  <= 16'h0000;
      xramData_q  <= 8'h00;
      sfrRdata_q  <= 8'h00;
      lockState_q <= 2'h0;
    end else begin
      // status trails the lock by one cycle
      flashAddr_q <= flashAddr_d;
      flashData_q <= flashData_d;
      xramAddr_q  <= xramAddr_d;
      xramData_q  <= xramData_d;
      sfrRdata_q  <= sfrRdata_d;
      lockState_q <= state;
    end
  end

  // ==========================================================
  // outputs, all straight from flip-flops
  // so no pin glitches on a decode
  assign sfrRdata        = sfrRdata_q;
  assign flashProgram    = flashProgram_q;
  assign flashErase      = flashErase_q;
  assign flashAddr       = flashAddr_q;
  assign flashData       = flashData_q;
  assign xramWrite       = xramWrite_q;
  assign xramAddr        = xramAddr_q;
  assign xramData        = xramData_q;
  assign flashErrorReset = errReset_q;
  assign lockState       = lockState_q;
  // firmware may poll busy for the end
  assign flashBusy       = opBusy_q;

endmodule // flash_write_erase_lock_key

`default_nettype wire

// ===== src/key_lock_fsm.sv
// lock-and-key state machine for flash writes and erases
`default_nettype none
`include "flash_defs.svh"

module key_lock_fsm (
  // clock and reset
  input  wire logic                 mclk,
  input  wire logic                 resetn,
  // key register writes
  input  wire logic                 keyWrite,
  input  wire logic [7:0]           keyData,
  // flash operation events
  input  wire logic                 attempt,
  input  wire logic                 busy,
  input  wire logic                 opDone,
  // current state
  output var  flash_pkg::lock_state_t state
);

  flash_pkg::lock_state_t state_q;  // current lock state
  flash_pkg::lock_state_t state_d;  // next lock state

  // ==========================================================
  // next state
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      flash_pkg::LOCK_LOCKED: begin
        if (attempt) begin
          state_d = flash_pkg::LOCK_DISABLED;
        end else if (keyWrite) begin
          // any code but the first one locks for good
          state_d = (keyData == `KEY_FIRST) ? flash_pkg::LOCK_KEY_ONE
                                            : flash_pkg::LOCK_DISABLED;
        end
      end
      flash_pkg::LOCK_KEY_ONE: begin
        if (attempt) begin
          state_d = flash_pkg::LOCK_DISABLED;
        end else if (keyWrite) begin
          state_d = (keyData == `KEY_SECOND) ? flash_pkg::LOCK_OPEN
                                             : flash_pkg::LOCK_DISABLED;
        end
      end
      flash_pkg::LOCK_OPEN: begin
        // a second attempt while the first is still running is refused
        if (attempt && busy) begin
          state_d = flash_pkg::LOCK_DISABLED;
        end else if (keyWrite) begin
          state_d = flash_pkg::LOCK_DISABLED;
        end else if (opDone) begin
          state_d = flash_pkg::LOCK_LOCKED;
        end
      end
      flash_pkg::LOCK_DISABLED: begin
        state_d = flash_pkg::LOCK_DISABLED;    // only reset leaves
      end
    endcase
  end

  // ==========================================================
  // state register
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state_q <= flash_pkg::LOCK_LOCKED;
    end else begin
      state_q <= state_d;
    end
  end

  assign state = state_q;

endmodule // key_lock_fsm

`default_nettype wire

// ===== tb/flash_array_model.sv
// behavioural flash array answering program and erase strobes
`default_nettype none

module flash_array_model (
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       resetn,
  // operation strobes and answer delay
  input  wire logic       flashProgram,
  input  wire logic       flashErase,
  input  wire logic [3:0] lat,
  // completion pulse
  output logic            flashDone
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;  // cycles left in the running operation
  // =========================================
  // busy countdown; lat must be at least 1 or no answer comes
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cnt       <= 0;
      flashDone <= 1'b0;
    end else begin
      flashDone <= (cnt == 1);
      if (flashProgram || flashErase) begin
        cnt <= int'(lat);
      end else if (cnt != 0) begin
        cnt <= cnt - 1;
      end
    end
  end
endmodule  // flash_array_model

`default_nettype wire

// ===== tb/flash_lock_checker_sva.sv
// assertions on the ports of the flash lock-and-key block
`default_nettype none
`include "flash_defs.svh"

module flash_lock_checker (
  // clock and reset
  input wire logic              mclk,
  input wire logic              resetn,
  // register port
  input wire logic [7:0]        sfrAddr,
  input wire logic              sfrWrite,
  input wire logic              sfrRead,
  input wire logic [7:0]        sfrWdata,
  input wire logic [7:0]        sfrRdata,
  // external-move write
  input wire logic              movxWrite,
  input wire flash_pkg::xaddr_t movxAddr,
  input wire logic [7:0]        movxData,
  // supply and flash array
  input wire logic              supplyMonEnabled,
  input wire logic              supplyMonIsResetSource,
  input wire logic              flashDone,
  input wire logic              flashProgram,
  input wire logic              flashErase,
  input wire flash_pkg::xaddr_t flashAddr,
  input wire logic [7:0]        flashData,
  // data memory and status
  input wire logic              xramWrite,
  input wire flash_pkg::xaddr_t xramAddr,
  input wire logic              flashErrorReset,
  input wire logic [1:0]        lockState,
  input wire logic              flashBusy
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  // =========================================
  // shadow of the control bits, rebuilt from register writes
  logic weQ;
  logic eeQ;
  wire pscWr    = sfrWrite && sfrAddr == `PSC_ADDR;
  wire keyWr    = sfrWrite && sfrAddr == `KEY_ADDR;
  wire supplyOk = supplyMonEnabled && supplyMonIsResetSource;
  wire flashTry = movxWrite && weQ;
  logic keyWrD, doneD, tryD;  // key write, done and judged attempt one cycle ago
  always_ff @(posedge mclk) begin
    {keyWrD, doneD, tryD} <= {keyWr, flashDone, flashTry && supplyOk};
  end
  // lockState lags one cycle, so grants need a quiet previous cycle
  wire openNow  = lockState == 2'b10 && !flashBusy && !keyWrD && !doneD;
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      weQ <= 1'b0;
      eeQ <= 1'b0;
    end else if (pscWr) begin
      weQ <= sfrWdata[0];
      eeQ <= sfrWdata[1];
    end
  end
  // =========================================
  // assertions
  route_xram_a: assert property (movxWrite && !weQ |=>
    xramWrite && xramAddr == $past(movxAddr) && !flashProgram && !flashErase)
    else $error("data memory write not routed");
  program_grant_a: assert property (flashTry && !eeQ && supplyOk && openNow |=>
    flashProgram && flashAddr == $past(movxAddr) && flashData == $past(movxData))
    else $error("granted program strobe wrong");
  page_erase_a: assert property (flashTry && eeQ && supplyOk && openNow |=>
    flashErase && !flashProgram && flashAddr == {$past(movxAddr[15:9]), 9'h000} && flashData == 8'hFF)
    else $error("page erase strobe wrong");
  locked_try_a: assert property (flashTry && supplyOk && lockState == 2'b00 && !$past(keyWr) |=>
    !flashProgram && !flashErase ##1 lockState == 2'b11)
    else $error("locked attempt not refused");
  lock_sticky_a: assert property (lockState == 2'b11 |=> lockState == 2'b11)
    else $error("disabled state left without reset");
  bad_first_a: assert property (keyWr && sfrWdata != `KEY_FIRST && lockState == 2'b00 && !$past(keyWr)
    |-> ##2 lockState == 2'b11)
    else $error("non-first key did not lock");
  relock_done_a: assert property (flashBusy && flashDone && !keyWr && !flashTry && lockState == 2'b10
    && !keyWrD && !tryD |=> !flashBusy ##1 lockState == 2'b00)
    else $error("no relock after operation");
  busy_try_a: assert property (flashTry && supplyOk && flashBusy |=>
    !flashProgram && !flashErase ##1 lockState == 2'b11)
    else $error("busy attempt not refused");
  supply_fault_a: assert property (flashTry && !supplyOk |=>
    flashErrorReset && !flashProgram && !flashErase)
    else $error("supply fault not reported");
  key_read_a: assert property (sfrRead && sfrAddr == `KEY_ADDR |=> sfrRdata == {6'h00, lockState})
    else $error("key read not lock state");
  ctrl_read_a: assert property (sfrRead && !sfrWrite && sfrAddr == `PSC_ADDR |=>
    sfrRdata == {6'h00, eeQ, weQ})
    else $error("control read wrong");
  // =========================================
  // covers
  cover property (flashProgram);
  cover property (flashErase);
  cover property (lockState == 2'b11);
endmodule  // flash_lock_checker

bind flash_write_erase_lock_key flash_lock_checker u_chk (
  .mclk, .resetn, .sfrAddr, .sfrWrite, .sfrRead, .sfrWdata, .sfrRdata, .movxWrite, .movxAddr,
  .movxData, .supplyMonEnabled, .supplyMonIsResetSource, .flashDone, .flashProgram, .flashErase,
  .flashAddr, .flashData, .xramWrite, .xramAddr, .flashErrorReset, .lockState, .flashBusy
);

`default_nettype wire

// ===== tb/tb_flash_write_erase_lock_key.sv
// self-checking bench of the flash lock-and-key block
`default_nettype none
`include "flash_defs.svh"

module tb_flash_write_erase_lock_key;
  timeunit 1ns;
  timeprecision 1ps;
  // =========================================
  // stimulus, outputs and scoreboard
  logic              mclk = 1'b0, resetn = 1'b0, smEn = 1'b1, smSrc = 1'b1;
  logic [7:0]        sfrAddr = 8'h00, sfrWdata = 8'h00, movxData = 8'h00;
  logic              sfrWrite = 1'b0, sfrRead = 1'b0, movxWrite = 1'b0;
  flash_pkg::xaddr_t movxAddr = 16'h0000, lastAddr, lastX;
  logic [3:0]        lat = 4'h2;
  wire logic [7:0]   sfrRdata, flashData, xramData, lastData;
  wire logic         flashDone, flashProgram, flashErase, xramWrite, flashErrorReset, flashBusy;
  flash_pkg::xaddr_t flashAddr, xramAddr;
  wire logic [1:0]   lockState;
  int                nProg = 0, nErase = 0, nXram = 0, nErr = 0, n_mismatch = 0, total_checks = 0;
  logic [7:0]        dataQ, xDataQ;
  assign lastData = dataQ;

  always #10 mclk = ~mclk;

  flash_write_erase_lock_key u_dut (.mclk(mclk), .resetn(resetn), .sfrAddr(sfrAddr),
    .sfrWrite(sfrWrite), .sfrRead(sfrRead), .sfrWdata(sfrWdata), .sfrRdata(sfrRdata),
    .movxWrite(movxWrite), .movxAddr(movxAddr), .movxData(movxData), .supplyMonEnabled(smEn),
    .supplyMonIsResetSource(smSrc), .flashDone(flashDone), .flashProgram(flashProgram),
    .flashErase(flashErase), .flashAddr(flashAddr), .flashData(flashData), .xramWrite(xramWrite),
    .xramAddr(xramAddr), .xramData(xramData), .flashErrorReset(flashErrorReset),
    .lockState(lockState), .flashBusy(flashBusy));
  flash_array_model u_array (.mclk(mclk), .resetn(resetn), .flashProgram(flashProgram),
    .flashErase(flashErase), .lat(lat), .flashDone(flashDone));

  // one-cycle strobes are counted where they stand
  always @(posedge mclk) begin
    if (flashProgram || flashErase) begin
      lastAddr = flashAddr;
      dataQ = flashData;
    end
    nProg += int'(flashProgram === 1'b1);
    nErase += int'(flashErase === 1'b1);
    nErr += int'(flashErrorReset === 1'b1);
    if (xramWrite === 1'b1) begin
      nXram++;
      lastX = xramAddr;
      xDataQ = xramData;
    end
  end
  // =========================================
  // access tasks
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic sfrWr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    sfrAddr <= a;
    sfrWdata <= d;
    sfrWrite <= 1'b1;
    @(posedge mclk);
    sfrWrite <= 1'b0;
  endtask
  task automatic sfrRd(input logic [7:0] a, input logic [7:0] exp, input string what);
    @(posedge mclk);
    sfrAddr <= a;
    sfrRead <= 1'b1;
    @(posedge mclk);
    sfrRead <= 1'b0;
    @(posedge mclk);
    #1 chk(what, {8'h00, exp}, {8'h00, sfrRdata});
  endtask
  task automatic xw(input flash_pkg::xaddr_t a, input logic [7:0] d);
    @(posedge mclk);
    movxAddr <= a;
    movxData <= d;
    movxWrite <= 1'b1;
    @(posedge mclk);
    movxWrite <= 1'b0;
    repeat (2) @(posedge mclk);
  endtask
  task automatic unlock();
    sfrWr(`KEY_ADDR, `KEY_FIRST);
    sfrWr(`KEY_ADDR, `KEY_SECOND);
  endtask
  task automatic waitIdle();
    for (int i = 0; i < 40 && flashBusy !== 1'b0; i++) @(posedge mclk);
    chk("busy", 16'h0000, {15'h0000, flashBusy});
  endtask
  task automatic doRst();
    @(posedge mclk);
    resetn <= 1'b0;
    repeat (8) @(posedge mclk);
    resetn <= 1'b1;
  endtask
  task automatic test_done();
    if (n_mismatch == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // =========================================
  // scenarios
  initial begin
    doRst();
    sfrRd(`PSC_ADDR, `PSC_RESET, "control reset");
    sfrRd(`KEY_ADDR, `KEY_RESET, "key reset");
    sfrRd(8'h55, 8'h00, "unmapped read");
    sfrWr(`PSC_ADDR, 8'hFF);
    sfrRd(`PSC_ADDR, 8'h03, "reserved bits");
    sfrWr(`PSC_ADDR, 8'h00);
    xw(16'hABCD, 8'h3C);
    chk("xram count", 16'd1, 16'(nXram));
    chk("xram addr", 16'hABCD, lastX);
    chk("xram data", 16'h003C, {8'h00, xDataQ});
    chk("flash blocked", 16'd0, 16'(nProg + nErase));
    sfrWr(`KEY_ADDR, `KEY_FIRST);
    sfrRd(`KEY_ADDR, 8'h01, "key one");
    sfrWr(`KEY_ADDR, `KEY_SECOND);
    sfrRd(`KEY_ADDR, 8'h02, "key open");
    sfrWr(`PSC_ADDR, 8'h01);
    xw(16'h1234, 8'h5A);
    chk("program count", 16'd1, 16'(nProg));
    chk("program addr", 16'h1234, lastAddr);
    chk("program data", 16'h005A, {8'h00, lastData});
    waitIdle();
    sfrRd(`KEY_ADDR, 8'h00, "relock program");
    lat <= 4'h9;
    unlock();
    sfrWr(`PSC_ADDR, 8'h03);
    xw(16'h13FF, 8'h37);
    chk("erase count", 16'd1, 16'(nErase));
    chk("erase base", 16'h1200, lastAddr);
    chk("erase data", 16'h00FF, {8'h00, lastData});
    waitIdle();
    sfrRd(`KEY_ADDR, 8'h00, "relock erase");
    unlock();
    sfrWr(`PSC_ADDR, 8'h01);
    for (int k = 0; k < 2; k++) begin
      {smEn, smSrc} <= k[0] ? 2'b10 : 2'b01;
      xw(16'h0100, 8'h11);
      chk("error reset", 16'(k + 1), 16'(nErr));
    end
    {smEn, smSrc} <= 2'b11;
    chk("fault no program", 16'd1, 16'(nProg));
    sfrRd(`KEY_ADDR, 8'h02, "fault keeps lock");
    xw(16'h0100, 8'h11);
    chk("program after fault", 16'd2, 16'(nProg));
    waitIdle();
    xw(16'h0200, 8'h22);
    chk("locked no program", 16'd2, 16'(nProg));
    sfrRd(`KEY_ADDR, 8'h03, "locked attempt");
    unlock();
    sfrRd(`KEY_ADDR, 8'h03, "sticky lock");
    doRst();
    sfrWr(`KEY_ADDR, `KEY_FIRST);
    sfrWr(`KEY_ADDR, 8'h12);
    sfrRd(`KEY_ADDR, 8'h03, "wrong second key");
    doRst();
    sfrWr(`KEY_ADDR, 8'h00);
    sfrRd(`KEY_ADDR, 8'h03, "deliberate lock");
    doRst();
    unlock();
    sfrWr(`PSC_ADDR, 8'h01);
    xw(16'h0300, 8'h33);
    xw(16'h0301, 8'h44);
    chk("busy no program", 16'd3, 16'(nProg));
    sfrRd(`KEY_ADDR, 8'h03, "busy attempt");
    test_done();
  end
  // hang guard, far beyond the fewer than two hundred cycles the scenarios take
  initial begin
    repeat (20000) @(posedge mclk);
    n_mismatch++;
    test_done();
  end
endmodule  // tb_flash_write_erase_lock_key

`default_nettype wire
